/* File: logic/alu_consts.vh */
`ifndef ALU_CONSTS_VH
`define ALU_CONSTS_VH

// operation codes on i_op
`define ALU_OP_ADD 4'h0
`define ALU_OP_ADDC 4'h1
`define ALU_OP_SUB 4'h2
`define ALU_OP_SUBB 4'h3
`define ALU_OP_AND 4'h4
`define ALU_OP_IOR 4'h5
`define ALU_OP_XOR 4'h6
`define ALU_OP_ASR 4'h7
`define ALU_OP_SL 4'h8
`define ALU_OP_LSR 4'h9
`define ALU_OP_MUL 4'ha
`define ALU_OP_DIV 4'hb

// multiplier modes on i_mul_mode
`define ALU_MUL_SS 3'h0
`define ALU_MUL_UU 3'h1
`define ALU_MUL_US 3'h2
`define ALU_MUL_SLIT 3'h3
`define ALU_MUL_ULIT 3'h4
`define ALU_MUL_U8 3'h5

// status_word bit positions
`define ALU_SW_BORROW 0
`define ALU_SW_NIL 1
`define ALU_SW_WRAP 2
`define ALU_SW_MSB 3
`define ALU_SW_NIBBLE 8
`define ALU_SW_MASK 16'h010f
`define ALU_SW_RESET 16'h0000

// register bus map, byte addresses
`define ALU_ADDR_STATUS 8'h00
`define ALU_ADDR_QUOT 8'h04
`define ALU_ADDR_REM 8'h08
`define ALU_ADDR_CTRL 8'h0c
`define ALU_CTRL_RESET 1'b1

// working register indices for divide results
`define ALU_QUOT_IDX 4'h0
`define ALU_REM_IDX 4'h1

// divide iterations, one per divisor bit
`define ALU_DIV_CYCLES 5'd16

`endif

/* File: logic/alu_div.v */
`timescale 1ns/100ps
`default_nettype none
`include "alu_consts.vh"

module alu_div #(
  parameter WIDTH = 16
) (
  input wire i_core_clk,
  input wire i_rst_n,
  input wire i_start,
  input wire i_signed,
  input wire i_long,
  input wire [2*WIDTH-1:0] i_dividend,
  input wire [WIDTH-1:0] i_divisor,
  output reg o_done,
  output reg [WIDTH-1:0] o_quot,
  output reg [WIDTH-1:0] o_rem,
  output reg o_ovf
);

  reg busy;
  reg [4:0] count;
  reg [WIDTH:0] part;
  reg [WIDTH-1:0] qsh;
  reg [WIDTH-1:0] dmag;
  reg neg_q;
  reg neg_r;
  reg ovf;
  reg [2*WIDTH-1:0] next_nmag;
  reg [WIDTH:0] next_trial;
  reg [2*WIDTH-1:0] dvd;

  always @* begin
    // 16-bit form sign- or zero-extends the low word
    if (i_long) begin
      dvd = i_dividend;
    end else if (i_signed) begin
      dvd = {{WIDTH{i_dividend[WIDTH-1]}}, i_dividend[WIDTH-1:0]};
    end else begin
      dvd = {{WIDTH{1'b0}}, i_dividend[WIDTH-1:0]};
    end
    next_nmag = (i_signed && dvd[2*WIDTH-1]) ? (~dvd + 1'b1) : dvd;
    next_trial = {part[WIDTH-1:0], qsh[WIDTH-1]};
  end

  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy <= 1'b0;
      count <= 5'd0;
      part <= {(WIDTH+1){1'b0}};
      qsh <= {WIDTH{1'b0}};
      dmag <= {WIDTH{1'b0}};
      neg_q <= 1'b0;
      neg_r <= 1'b0;
      ovf <= 1'b0;
      o_done <= 1'b0;
      o_quot <= {WIDTH{1'b0}};
      o_rem <= {WIDTH{1'b0}};
      o_ovf <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_start && !busy) begin
        busy <= 1'b1;
        count <= `ALU_DIV_CYCLES;
        part <= {1'b0, next_nmag[2*WIDTH-1:WIDTH]};
        qsh <= next_nmag[WIDTH-1:0];
        dmag <= (i_signed && i_divisor[WIDTH-1]) ? (~i_divisor + 1'b1)
                                                  : i_divisor;
        neg_q <= i_signed && (dvd[2*WIDTH-1] ^ i_divisor[WIDTH-1]);
        neg_r <= i_signed && dvd[2*WIDTH-1];
        ovf <= 1'b0;
      end else if (busy) begin
        // restoring step, one quotient bit per cycle
        if (next_trial >= {1'b0, dmag}) begin
          part <= next_trial - {1'b0, dmag};
          qsh <= {qsh[WIDTH-2:0], 1'b1};
        end else begin
          part <= next_trial;
          qsh <= {qsh[WIDTH-2:0], 1'b0};
        end
        if (count == `ALU_DIV_CYCLES && part[WIDTH-1:0] >= dmag) begin
          ovf <= 1'b1;
        end
        count <= count - 5'd1;
        if (count == 5'd1) begin
          busy <= 1'b0;
          o_done <= 1'b1;
        end
      end
      if (busy && count == 5'd0) begin
        busy <= 1'b0;
      end
      if (o_done) begin
        o_quot <= neg_q ? (~qsh + 1'b1) : qsh;
        o_rem <= neg_r ? (~part[WIDTH-1:0] + 1'b1) : part[WIDTH-1:0];
        o_ovf <= ovf || (dmag == {WIDTH{1'b0}});
      end
    end
  end

endmodule // alu_div

`default_nettype wire

/* File: logic/alu_core.v */
`timescale 1ns/100ps
`default_nettype none
`include "alu_consts.vh"

module alu_core #(
  parameter WIDTH = 16
) (
  input wire i_core_clk,
  input wire i_rst_n,
  input wire i_op_valid,
  input wire [3:0] i_op,
  input wire i_byte_mode,
  input wire [2:0] i_mul_mode,
  input wire i_div_signed,
  input wire i_div_long,
  input wire [WIDTH-1:0] i_src_a,
  input wire [WIDTH-1:0] i_src_a_hi,
  input wire [WIDTH-1:0] i_src_b,
  input wire [3:0] i_shamt,
  input wire i_src_mem,
  input wire i_dst_mem,
  input wire [3:0] i_dst_idx,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output reg o_pready,
  output reg o_pslverr,
  output reg o_res_valid,
  output reg [WIDTH-1:0] o_result,
  output reg [WIDTH-1:0] o_result_hi,
  output reg o_wr_pair,
  output reg o_wr_reg,
  output reg o_wr_mem,
  output reg [3:0] o_dst_idx,
  output reg o_illegal,
  output reg o_busy,
  output reg [WIDTH-1:0] o_status_word,
  output reg [WIDTH-1:0] o_quotient_reg,
  output reg [WIDTH-1:0] o_remainder_reg
);

  // {carry out, result}; byte mode works on the low byte only
  function [WIDTH:0] fn_shift;
    input [WIDTH-1:0] a;
    input [3:0] n;
    input [3:0] op;
    input byte_m;
    reg [WIDTH-1:0] aw;
    reg fill;
    reg [2*WIDTH+1:0] t;
    begin
      aw = byte_m ? {{(WIDTH-8){1'b0}}, a[7:0]} : a;
      fill = (op == `ALU_OP_ASR) && (byte_m ? a[7] : a[WIDTH-1]);
      if (byte_m) begin
        aw = {{(WIDTH-8){fill}}, a[7:0]};
      end
      if (op == `ALU_OP_SL) begin
        t = {{(WIDTH+2){1'b0}}, aw} << n;
        fn_shift = {byte_m ? t[8] : t[WIDTH], t[WIDTH-1:0]};
      end else begin
        t = {{(WIDTH+1){fill}}, aw, 1'b0} >> n;
        fn_shift = {t[0], t[WIDTH:1]};
      end
    end
  endfunction

  reg ctrl_en;
  reg [4:0] flags;
  reg busy;
  reg div_start;
  reg [3:0] pend_idx;

  wire div_done;
  wire [WIDTH-1:0] div_quot;
  wire [WIDTH-1:0] div_rem;
  wire div_ovf;

  // combinational datapath
  reg is_sub;
  reg cin;
  reg [WIDTH-1:0] bx;
  reg [WIDTH:0] sum_w;
  reg [8:0] sum_b;
  reg [4:0] sum_n;
  reg [WIDTH-1:0] next_res;
  reg [WIDTH-1:0] next_res_hi;
  reg [4:0] next_flags;
  reg next_pair;
  reg next_illegal;
  reg [WIDTH:0] sh;
  reg is_shift;
  reg [WIDTH:0] ma;
  reg [WIDTH:0] mb;
  reg [2*WIDTH+1:0] prod;
  reg res_msb;
  reg res_zero;
  wire take;
  wire apb_acc;
  wire apb_hit;

  // no new op until the divide result is posted and o_busy falls
  assign take = i_op_valid && !busy && !o_busy && ctrl_en;
  assign apb_acc = i_psel && i_penable;
  assign apb_hit = (i_paddr == `ALU_ADDR_STATUS) ||
                   (i_paddr == `ALU_ADDR_QUOT) ||
                   (i_paddr == `ALU_ADDR_REM) ||
                   (i_paddr == `ALU_ADDR_CTRL);

  always @* begin
    is_sub = (i_op == `ALU_OP_SUB) || (i_op == `ALU_OP_SUBB);
    is_shift = (i_op == `ALU_OP_ASR) || (i_op == `ALU_OP_SL) ||
               (i_op == `ALU_OP_LSR);
    bx = is_sub ? ~i_src_b : i_src_b;
    case (i_op)
      `ALU_OP_ADD: cin = 1'b0;
      `ALU_OP_SUB: cin = 1'b1;
      default: cin = flags[`ALU_SW_BORROW];
    endcase
    sum_w = {1'b0, i_src_a} + {1'b0, bx} + {{WIDTH{1'b0}}, cin};
    sum_b = {1'b0, i_src_a[7:0]} + {1'b0, bx[7:0]} + {8'h00, cin};
    sum_n = {1'b0, i_src_a[3:0]} + {1'b0, bx[3:0]} + {4'h0, cin};
    sh = fn_shift(i_src_a, i_shamt, i_op, i_byte_mode);
    // operands extended to 17 bits, sign chosen per mode
    case (i_mul_mode)
      `ALU_MUL_SS: begin
        ma = {i_src_a[WIDTH-1], i_src_a};
        mb = {i_src_b[WIDTH-1], i_src_b};
      end
      `ALU_MUL_US: begin
        ma = {1'b0, i_src_a};
        mb = {i_src_b[WIDTH-1], i_src_b};
      end
      `ALU_MUL_SLIT: begin
        ma = {i_src_a[WIDTH-1], i_src_a};
        mb = {{(WIDTH-4){1'b0}}, i_src_b[4:0]};
      end
      `ALU_MUL_ULIT: begin
        ma = {1'b0, i_src_a};
        mb = {{(WIDTH-4){1'b0}}, i_src_b[4:0]};
      end
      `ALU_MUL_U8: begin
        ma = {{(WIDTH-7){1'b0}}, i_src_a[7:0]};
        mb = {{(WIDTH-7){1'b0}}, i_src_b[7:0]};
      end
      default: begin
        ma = {1'b0, i_src_a};
        mb = {1'b0, i_src_b};
      end
    endcase
    prod = $signed(ma) * $signed(mb);
    next_res = i_src_a;
    next_res_hi = {WIDTH{1'b0}};
    next_pair = 1'b0;
    next_illegal = 1'b0;
    next_flags = flags;
    case (i_op)
      `ALU_OP_ADD, `ALU_OP_ADDC, `ALU_OP_SUB, `ALU_OP_SUBB: begin
        // byte ops keep the upper byte of the operand
        if (i_byte_mode) begin
          next_res = {i_src_a[WIDTH-1:8], sum_b[7:0]};
          next_flags[0] = sum_b[8];
          next_flags[4] = sum_n[4];
          next_flags[2] = (i_src_a[7] == bx[7]) &&
                          (sum_b[7] != i_src_a[7]);
        end else begin
          next_res = sum_w[WIDTH-1:0];
          next_flags[0] = sum_w[WIDTH];
          next_flags[4] = sum_b[8];
          next_flags[2] = (i_src_a[WIDTH-1] == bx[WIDTH-1]) &&
                          (sum_w[WIDTH-1] != i_src_a[WIDTH-1]);
        end
      end
      `ALU_OP_AND: next_res = i_src_a & i_src_b;
      `ALU_OP_IOR: next_res = i_src_a | i_src_b;
      `ALU_OP_XOR: next_res = i_src_a ^ i_src_b;
      `ALU_OP_ASR, `ALU_OP_SL, `ALU_OP_LSR: begin
        next_res = i_byte_mode ? {i_src_a[WIDTH-1:8], sh[7:0]}
                               : sh[WIDTH-1:0];
        if (i_shamt != 4'h0) begin
          next_flags[0] = sh[WIDTH];
        end
        // multi-bit form may not touch memory
        next_illegal = is_shift && (i_shamt > 4'h1) &&
                       (i_src_mem || i_dst_mem);
      end
      `ALU_OP_MUL: begin
        next_res = prod[WIDTH-1:0];
        next_res_hi = prod[2*WIDTH-1:WIDTH];
        next_pair = (i_mul_mode != `ALU_MUL_U8);
      end
      default: next_res = i_src_a;
    endcase
    // sign and zero for all but multiply and divide
    res_msb = i_byte_mode ? next_res[7] : next_res[WIDTH-1];
    res_zero = i_byte_mode ? (next_res[7:0] == 8'h00)
                           : (next_res == {WIDTH{1'b0}});
    if (i_op != `ALU_OP_MUL && i_op <= `ALU_OP_LSR) begin
      next_flags[3] = res_msb;
      if (i_op == `ALU_OP_ADDC || i_op == `ALU_OP_SUBB) begin
        next_flags[1] = flags[1] && res_zero;
      end else begin
        next_flags[1] = res_zero;
      end
    end
  end

  alu_div #(
    .WIDTH(WIDTH)
  ) u_div (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_start(div_start),
    .i_signed(i_div_signed),
    .i_long(i_div_long),
    .i_dividend({i_src_a_hi, i_src_a}),
    .i_divisor(i_src_b),
    .o_done(div_done),
    .o_quot(div_quot),
    .o_rem(div_rem),
    .o_ovf(div_ovf)
  );

  always @* begin
    // dividend pair and any divisor come in on the operands
    div_start = take && (i_op == `ALU_OP_DIV);
  end

  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_en <= `ALU_CTRL_RESET;
      flags <= 5'h00;
      busy <= 1'b0;
      pend_idx <= 4'h0;
      o_prdata <= 32'h0000_0000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_res_valid <= 1'b0;
      o_result <= {WIDTH{1'b0}};
      o_result_hi <= {WIDTH{1'b0}};
      o_wr_pair <= 1'b0;
      o_wr_reg <= 1'b0;
      o_wr_mem <= 1'b0;
      o_dst_idx <= 4'h0;
      o_illegal <= 1'b0;
      o_busy <= 1'b0;
      o_status_word <= `ALU_SW_RESET;
      o_quotient_reg <= {WIDTH{1'b0}};
      o_remainder_reg <= {WIDTH{1'b0}};
    end else begin
      o_res_valid <= 1'b0;
      o_wr_reg <= 1'b0;
      o_wr_mem <= 1'b0;
      o_wr_pair <= 1'b0;
      o_illegal <= 1'b0;
      // register bus: one wait state, pready from a flop one cycle after penable
      o_pready <= apb_acc && !o_pready;
      if (apb_acc && !o_pready) begin
        o_pslverr <= !apb_hit;
        case (i_paddr)
          `ALU_ADDR_STATUS: o_prdata <= {16'h0000, o_status_word};
          `ALU_ADDR_QUOT: o_prdata <= {16'h0000, o_quotient_reg};
          `ALU_ADDR_REM: o_prdata <= {16'h0000, o_remainder_reg};
          `ALU_ADDR_CTRL: o_prdata <= {31'h0000_0000, ctrl_en};
          default: o_prdata <= 32'h0000_0000;
        endcase
      end
      if (apb_acc && o_pready && i_pwrite) begin
        if (i_paddr == `ALU_ADDR_STATUS) begin
          flags <= {i_pwdata[`ALU_SW_NIBBLE], i_pwdata[3:0]};
        end
        if (i_paddr == `ALU_ADDR_CTRL) begin
          ctrl_en <= i_pwdata[0];
        end
      end
      // hardware flag update wins over a same-cycle bus write
      if (take && i_op != `ALU_OP_DIV) begin
        o_illegal <= next_illegal;
        if (!next_illegal) begin
          flags <= next_flags;
          o_res_valid <= 1'b1;
          o_result <= next_res;
          o_result_hi <= next_res_hi;
          o_wr_pair <= next_pair;
          o_wr_reg <= !i_dst_mem;
          o_wr_mem <= i_dst_mem;
          o_dst_idx <= i_dst_idx;
        end
      end
      if (div_start) begin
        busy <= 1'b1;
        o_busy <= 1'b1;
        pend_idx <= `ALU_QUOT_IDX;
      end
      if (div_done) begin
        busy <= 1'b0;
      end
      if (busy && !div_done && !o_busy) begin
        o_busy <= 1'b1;
      end
      // divider results register one cycle after its done pulse
      if (!busy && o_busy && !div_start) begin
        o_busy <= 1'b0;
        o_quotient_reg <= div_quot;
        o_remainder_reg <= div_rem;
        o_result <= div_quot;
        o_result_hi <= div_rem;
        o_res_valid <= 1'b1;
        o_wr_reg <= 1'b1;
        o_wr_pair <= 1'b1;
        o_dst_idx <= pend_idx;
        flags[2] <= div_ovf;
      end
      // status_word lags flags by one cycle
      o_status_word <= {{(WIDTH-9){1'b0}}, flags[4], 4'h0, flags[3:0]};
    end
  end

endmodule // alu_core

`default_nettype wire

/* File: tb/alu_core_props.sv */
`timescale 1ns/100ps
`default_nettype none
`include "alu_consts.vh"
module alu_core_props #(
  parameter WIDTH = 16
) (
  input wire i_core_clk,
  input wire i_rst_n,
  input wire i_op_valid,
  input wire [3:0] i_op,
  input wire i_byte_mode,
  input wire [WIDTH-1:0] i_src_a,
  input wire [WIDTH-1:0] i_src_b,
  input wire [3:0] i_shamt,
  input wire i_src_mem,
  input wire i_dst_mem,
  input wire i_psel,
  input wire i_penable,
  input wire o_pready,
  input wire o_res_valid,
  input wire [WIDTH-1:0] o_result,
  input wire [WIDTH-1:0] o_result_hi,
  input wire o_wr_pair,
  input wire o_wr_reg,
  input wire o_wr_mem,
  input wire [3:0] o_dst_idx,
  input wire o_illegal,
  input wire o_busy,
  input wire [WIDTH-1:0] o_status_word,
  input wire [WIDTH-1:0] o_quotient_reg,
  input wire [WIDTH-1:0] o_remainder_reg
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);
  // plain word op on registers while o_busy is low; ctrl_en is not checked
  wire plain;
  assign plain = i_op_valid && !o_busy && !i_byte_mode && !i_src_mem &&
    !i_dst_mem;
  sequence s_div_end;
    ##18 ($fell(o_busy) && o_res_valid);
  endsequence
  sequence s_div_out;
    o_res_valid && $past(o_busy);
  endsequence
  a_div_length: assert property ($rose(o_busy) |-> s_div_end)
    else $error("divide length wrong");
  a_busy_quiet: assert property (o_busy |-> !o_res_valid && !o_illegal)
    else $error("result while busy");
  a_div_target: assert property (s_div_out |->
    o_dst_idx == 4'h0 && o_wr_pair && o_wr_reg)
    else $error("divide destination wrong");
  a_div_regs: assert property (s_div_out |->
    o_quotient_reg == o_result && o_remainder_reg == o_result_hi)
    else $error("divide registers differ");
  a_shift_refused: assert property (o_illegal |->
    $past(i_shamt) > 4'h1 && !o_wr_mem && !o_wr_reg)
    else $error("illegal shift handling");
  a_sw_unused: assert property (
    (o_status_word & ~`ALU_SW_MASK) == 16'h0000)
    else $error("status unused bits set");
  a_left_fill: assert property (
    $past(plain && i_op == `ALU_OP_SL) && o_res_valid |->
    o_result == $past(i_src_a) << $past(i_shamt))
    else $error("left shift wrong");
  a_arith_fill: assert property (
    $past(plain && i_op == `ALU_OP_ASR) && o_res_valid |->
    o_result == $unsigned($signed($past(i_src_a)) >>> $past(i_shamt)))
    else $error("arith shift wrong");
  a_add_word: assert property (
    $past(plain && i_op == `ALU_OP_ADD) && o_res_valid |->
    o_result == WIDTH'($past(i_src_a) + $past(i_src_b)))
    else $error("add result wrong");
  a_apb_answer: assert property (i_psel && $rose(i_penable) |=> o_pready)
    else $error("bus answer late");
endmodule // alu_core_props
bind alu_core alu_core_props #(.WIDTH(WIDTH)) props_u (.i_core_clk,
  .i_rst_n, .i_op_valid, .i_op, .i_byte_mode, .i_src_a, .i_src_b,
  .i_shamt, .i_src_mem, .i_dst_mem, .i_psel, .i_penable, .o_pready,
  .o_res_valid, .o_result, .o_result_hi, .o_wr_pair, .o_wr_reg,
  .o_wr_mem, .o_dst_idx, .o_illegal, .o_busy, .o_status_word,
  .o_quotient_reg, .o_remainder_reg);
`default_nettype wire

/* File: tb/alu_wfile.sv */
`timescale 1ns/100ps
`default_nettype none
module alu_wfile (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_res_valid,
  input wire logic i_wr_reg,
  input wire logic i_wr_pair,
  input wire logic [3:0] i_dst_idx,
  input wire logic [15:0] i_result,
  input wire logic [15:0] i_result_hi
);
  logic [15:0] wreg [16];
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int k = 0; k < 16; k++) begin
        wreg[k] <= 16'h0000;
      end
    end else if (i_res_valid && i_wr_reg) begin
      wreg[i_dst_idx] <= i_result;
      if (i_wr_pair) begin
        wreg[i_dst_idx + 4'h1] <= i_result_hi;
      end
    end
  end
endmodule // alu_wfile
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "alu_consts.vh"
module tb;
  logic i_core_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_op_valid = 1'b0, i_byte_mode = 1'b0, i_div_signed = 1'b0;
  logic i_div_long = 1'b0, i_src_mem = 1'b0, i_dst_mem = 1'b0;
  logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0, rerr;
  logic [3:0] i_op = 4'h0, i_shamt = 4'h0, i_dst_idx = 4'h6;
  logic [2:0] i_mul_mode = 3'h0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0000_0000, rdat;
  logic [15:0] i_src_a = 16'h0000, i_src_a_hi = 16'h0000;
  logic [15:0] i_src_b = 16'h0000;
  int lat, errors = 0, samples_checked = 0;
  wire [31:0] o_prdata;
  wire [15:0] o_result, o_result_hi, o_status_word;
  wire [15:0] o_quotient_reg, o_remainder_reg;
  wire o_pready, o_pslverr, o_res_valid, o_wr_pair, o_wr_reg;
  wire o_wr_mem, o_illegal, o_busy;
  wire [3:0] o_dst_idx;
  always #10 i_core_clk = ~i_core_clk;
  alu_core dut_u (.i_core_clk, .i_rst_n, .i_op_valid, .i_op, .i_byte_mode,
    .i_mul_mode, .i_div_signed, .i_div_long, .i_src_a, .i_src_a_hi,
    .i_src_b, .i_shamt, .i_src_mem, .i_dst_mem, .i_dst_idx, .i_psel,
    .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready,
    .o_pslverr, .o_res_valid, .o_result, .o_result_hi, .o_wr_pair,
    .o_wr_reg, .o_wr_mem, .o_dst_idx, .o_illegal, .o_busy,
    .o_status_word, .o_quotient_reg, .o_remainder_reg);
  alu_wfile wf_u (.i_core_clk, .i_rst_n, .i_res_valid(o_res_valid),
    .i_wr_reg(o_wr_reg), .i_wr_pair(o_wr_pair), .i_dst_idx(o_dst_idx),
    .i_result(o_result), .i_result_hi(o_result_hi));
  task automatic complete_run;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic timeout;
    errors++;
    complete_run();
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    int n;
    @(posedge i_core_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_core_clk);
    i_penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    if (n >= 20) timeout();
    rdat = o_prdata;
    rerr = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task automatic op(input logic [3:0] c, input logic b,
      input logic [15:0] a, bb, input logic [3:0] s);
    @(posedge i_core_clk);
    i_op <= c;
    i_byte_mode <= b;
    i_src_a <= a;
    i_src_b <= bb;
    i_shamt <= s;
    i_op_valid <= 1'b1;
    @(posedge i_core_clk);
    i_op_valid <= 1'b0;
    lat = 0;
    do begin
      @(negedge i_core_clk);
      lat++;
    end while (o_res_valid !== 1'b1 && o_illegal !== 1'b1 && lat < 40);
    if (lat >= 40) timeout();
  endtask
  // sw of 16'hffff skips the status read
  task automatic t(input logic [3:0] c, input logic b,
      input logic [15:0] a, bb, input logic [3:0] s, input logic [15:0] r, sw);
    op(c, b, a, bb, s);
    chk("result", o_result, r);
    chk("wr_reg", o_wr_reg, 1'b1);
    chk("dst_idx", o_dst_idx, 4'h6);
    if (sw != 16'hffff) begin
      apb(1'b0, `ALU_ADDR_STATUS, 32'h0000_0000);
      chk("status", rdat, {16'h0000, sw});
    end
  endtask
  task automatic m(input logic [2:0] md, input logic [15:0] a, bb,
      input logic [31:0] e);
    @(posedge i_core_clk);
    i_mul_mode <= md;
    op(`ALU_OP_MUL, 1'b0, a, bb, 4'h0);
    chk("mul_lo", o_result, e[15:0]);
    chk("mul_pair", o_wr_pair, md != `ALU_MUL_U8);
    if (md != `ALU_MUL_U8) chk("mul_hi", o_result_hi, e[31:16]);
  endtask
  task automatic d(input logic sg, lg, input logic [15:0] hi, a, bb, q, rm);
    @(posedge i_core_clk);
    i_div_signed <= sg;
    i_div_long <= lg;
    i_src_a_hi <= hi;
    op(`ALU_OP_DIV, 1'b0, a, bb, 4'h0);
    chk("div_cycles", lat, 19);
    chk("quot", o_result, q);
    chk("rem", o_result_hi, rm);
    chk("quot_reg", o_quotient_reg, q);
    @(negedge i_core_clk);
    chk("wreg0", wf_u.wreg[0], q);
    chk("wreg1", wf_u.wreg[1], rm);
  endtask
  initial begin
    repeat (6) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      apb(1'b0, 8'(4 * k), 32'h0000_0000);
      chk("reset_val", rdat, {31'h0000_0000, k == 3});
    end
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk("unmapped", {rdat[30:0], rerr}, 32'h0000_0001);
    apb(1'b1, `ALU_ADDR_STATUS, 32'hffff_ffff);
    apb(1'b0, `ALU_ADDR_STATUS, 32'h0000_0000);
    chk("sw_rw", rdat, 32'h0000_010f);
    t(`ALU_OP_ADD, 1'b0, 16'h7fff, 16'h0001, 4'h0, 16'h8000, 16'h010c);
    t(`ALU_OP_SUB, 1'b0, 16'h0005, 16'h0005, 4'h0, 16'h0000, 16'h0103);
    t(`ALU_OP_SUB, 1'b0, 16'h0000, 16'h0001, 4'h0, 16'hffff, 16'h0008);
    t(`ALU_OP_ADD, 1'b1, 16'h127f, 16'h0001, 4'h0, 16'h1280, 16'h010c);
    t(`ALU_OP_ADD, 1'b1, 16'h12ff, 16'h0001, 4'h0, 16'h1200, 16'h0103);
    t(`ALU_OP_AND, 1'b0, 16'hf0f0, 16'h0ff0, 4'h0, 16'h00f0, 16'h0101);
    t(`ALU_OP_IOR, 1'b0, 16'h8000, 16'h0001, 4'h0, 16'h8001, 16'h0109);
    t(`ALU_OP_XOR, 1'b0, 16'h1234, 16'h1234, 4'h0, 16'h0000, 16'h0103);
    t(`ALU_OP_ADDC, 1'b0, 16'h0001, 16'h0001, 4'h0, 16'h0003, 16'h0000);
    t(`ALU_OP_SUBB, 1'b0, 16'h0005, 16'h0001, 4'h0, 16'h0003, 16'h0101);
    t(`ALU_OP_ASR, 1'b0, 16'h8000, 16'h0000, 4'hf, 16'hffff, 16'hffff);
    t(`ALU_OP_SL, 1'b0, 16'h0001, 16'h0000, 4'hf, 16'h8000, 16'hffff);
    t(`ALU_OP_LSR, 1'b0, 16'h8000, 16'h0000, 4'hf, 16'h0001, 16'hffff);
    t(`ALU_OP_ASR, 1'b0, 16'h4001, 16'h0000, 4'h1, 16'h2000, 16'hffff);
    t(`ALU_OP_LSR, 1'b0, 16'hffff, 16'h0000, 4'h0, 16'hffff, 16'hffff);
    @(posedge i_core_clk);
    i_src_mem <= 1'b1;
    op(`ALU_OP_SL, 1'b0, 16'h0001, 16'h0000, 4'h2);
    chk("illegal", o_illegal, 1'b1);
    op(`ALU_OP_SL, 1'b0, 16'h0001, 16'h0000, 4'h1);
    chk("single_mem", o_res_valid, 1'b1);
    @(posedge i_core_clk);
    i_src_mem <= 1'b0;
    i_dst_mem <= 1'b1;
    op(`ALU_OP_ADD, 1'b0, 16'h0001, 16'h0002, 4'h0);
    chk("wr_mem", {o_wr_mem, o_wr_reg}, 32'h0000_0002);
    @(posedge i_core_clk);
    i_dst_mem <= 1'b0;
    m(`ALU_MUL_SS, 16'hfff0, 16'h0013, 32'hffff_fed0);
    m(`ALU_MUL_UU, 16'hfff0, 16'h0013, 32'h0012_fed0);
    m(`ALU_MUL_US, 16'hfff0, 16'hffff, 32'hffff_0010);
    m(`ALU_MUL_SLIT, 16'hfff0, 16'h0033, 32'hffff_fed0);
    m(`ALU_MUL_ULIT, 16'hfff0, 16'h0033, 32'h0012_fed0);
    m(`ALU_MUL_U8, 16'h12f0, 16'h2513, 32'h0000_11d0);
    d(1'b1, 1'b0, 16'h1234, 16'hfff9, 16'h0002, 16'hfffd, 16'hffff);
    d(1'b0, 1'b0, 16'h1234, 16'hfff9, 16'h0002, 16'h7ffc, 16'h0001);
    d(1'b0, 1'b1, 16'h0001, 16'h0000, 16'h0002, 16'h8000, 16'h0000);
    d(1'b1, 1'b1, 16'hffff, 16'hfff9, 16'h0002, 16'hfffd, 16'hffff);
    apb(1'b0, `ALU_ADDR_REM, 32'h0000_0000);
    chk("rem_reg", rdat, 32'h0000_ffff);
    apb(1'b1, `ALU_ADDR_CTRL, 32'h0000_0000);
    i_op <= `ALU_OP_ADD;
    i_op_valid <= 1'b1;
    repeat (3) begin
      @(negedge i_core_clk);
      chk("disabled", o_res_valid, 1'b0);
    end
    @(posedge i_core_clk);
    i_op_valid <= 1'b0;
    apb(1'b1, `ALU_ADDR_CTRL, 32'h0000_0001);
    complete_run();
  end
endmodule // tb
`default_nettype wire
